// ---- verilog/ssrp_port.sv ----
`timescale 1ns/1ps

module ssrp_port (
  // Clock and reset.
  input  wire logic                              clk,
  input  wire logic                              srst,
  // Serial bus, open drain.
  input  wire logic                              scl_i,
  input  wire logic                              sda_i,
  output wire logic                              sda_o,
  output wire logic                              sda_oe,
  // Alert line, open drain.
  output wire logic                              alert_o,
  output wire logic                              alert_oe,
  input  wire logic                              alert_set,
  // Tri-level address straps as comparator pairs.
  input  wire logic [ssrp_pkg::SSRP_STRAP_N-1:0] address_strap_pins_hi,
  input  wire logic [ssrp_pkg::SSRP_STRAP_N-1:0] address_strap_pins_lo,
  // Control from the device register set.
  input  wire logic                              mass_write_enable_bit,
  // Register access toward the device register set.
  output wire logic [ssrp_pkg::SSRP_PTR_W-1:0]   reg_ptr,
  output wire logic [7:0]                        reg_wr_data,
  output wire logic                              reg_wr_stb,
  input  wire logic [7:0]                        reg_rd_data
);
  import ssrp_pkg::*;

  // ----------------------------------------------------------------------
  // Line front end
  // ----------------------------------------------------------------------

  ssrp_line_if line ();  // Conditioned events from the pins.

  ssrp_line_front u_front (
    .clk        (clk),
    .srst       (srst),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .strap_hi_i (address_strap_pins_hi),
    .strap_lo_i (address_strap_pins_lo),
    .line       (line)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  ssrp_state_t state_ff;     // Serial engine state.
  ssrp_state_t nxt_state;
  ssrp_kind_t  kind_ff;      // Meaning of the byte in flight.
  ssrp_kind_t  nxt_kind;
  logic [2:0]  cnt_ff;       // Bit counter within a byte.
  logic [2:0]  nxt_cnt;
  logic [7:0]  sr_ff;        // Shift register, both directions.
  logic [7:0]  nxt_sr;
  logic [7:0]  hold_ff;      // Byte held for every read data phase.
  logic [7:0]  nxt_hold;
  logic        rw_ff;        // Direction bit of the last received address, matched or not.
  logic        nxt_rw;
  logic        ara_ff;       // Current read answers the alert address.
  logic        nxt_ara;
  logic        ack_on_ff;    // Acknowledge pulse under way.
  logic        nxt_ack_on;
  logic        first_ff;     // Next data byte is the first one.
  logic        nxt_first;
  logic        mack_ff;      // Master acknowledged the byte just sent.
  logic        nxt_mack;
  logic        sda_oe_ff;    // Pull the data line low.
  logic        nxt_sda_oe;
  logic [2:0]  ptr_ff;       // Internal register pointer.
  logic [2:0]  nxt_ptr;
  logic [7:0]  wr_data_ff;   // Last stored data byte.
  logic [7:0]  nxt_wr_data;
  logic        wr_stb_ff;    // One-cycle store strobe.
  logic        nxt_wr_stb;
  logic        alert_ff;     // Alert line pulled low.
  logic        alert_clr;    // Request to release the alert line.

  // ----------------------------------------------------------------------
  // Strap decode and address match
  // ----------------------------------------------------------------------

  // Turns a comparator pair into a pin level; neither means open.
  function automatic ssrp_pin_t pin_level(logic hi, logic lo);
    pin_level = hi ? SSRP_PIN_HIGH : (lo ? SSRP_PIN_LOW : SSRP_PIN_OPEN);
  endfunction

  // Maps the three pin levels onto the five low address bits.
  function automatic logic [4:0] strap_code(ssrp_pin_t p2, ssrp_pin_t p1,
                                            ssrp_pin_t p0);
    logic [2:0] low;
    logic       spare;
    low   = 3'h0;
    spare = 1'h0;
    case ({p1, p0})
      {SSRP_PIN_OPEN, SSRP_PIN_LOW}:  low = 3'h0;
      {SSRP_PIN_HIGH, SSRP_PIN_OPEN}: low = 3'h1;
      {SSRP_PIN_OPEN, SSRP_PIN_OPEN}: low = 3'h2;
      {SSRP_PIN_OPEN, SSRP_PIN_HIGH}: low = 3'h3;
      {SSRP_PIN_LOW, SSRP_PIN_LOW}:   low = 3'h4;
      {SSRP_PIN_HIGH, SSRP_PIN_HIGH}: low = 3'h5;
      {SSRP_PIN_LOW, SSRP_PIN_OPEN}:  low = 3'h6;
      {SSRP_PIN_LOW, SSRP_PIN_HIGH}:  low = 3'h7;
      default:                        spare = 1'h1;
    endcase
    if (spare) begin
      strap_code = SSRP_SPARE_BASE | {3'h0, p2};
    end else begin
      strap_code = {p2, low};
    end
  endfunction

  wire ssrp_pin_t pin2 = pin_level(line.strap_hi[2], line.strap_lo[2]);
  wire ssrp_pin_t pin1 = pin_level(line.strap_hi[1], line.strap_lo[1]);
  wire ssrp_pin_t pin0 = pin_level(line.strap_hi[0], line.strap_lo[0]);

  // Own address: fixed top bits above the strapped code.
  wire logic [6:0] own_addr = {SSRP_FIXED_MSBS,
                               strap_code(pin2, pin1, pin0)};

  // Byte as it stands once the eighth bit is shifted in.
  wire logic [7:0] rx_byte  = {sr_ff[6:0], line.sda_lvl};
  wire logic [6:0] rx_addr  = rx_byte[7:1];
  wire logic       rx_rw    = rx_byte[0];

  wire logic own_hit  = (rx_addr == own_addr);
  wire logic mass_hit = mass_write_enable_bit & ~rx_rw &
                        (rx_addr == SSRP_MASS_WRITE_ADDR);
  wire logic ara_hit  = alert_ff & rx_rw &
                        (rx_addr == SSRP_ALERT_RESP_ADDR);
  wire logic addr_hit = own_hit | mass_hit | ara_hit;
  wire logic last_bit = (cnt_ff == SSRP_LAST_BIT);

  // ----------------------------------------------------------------------
  // Serial engine, next state
  // ----------------------------------------------------------------------

  // Samples on clock rising edges and changes the data line on falling ones.
  always_comb begin
    nxt_state   = state_ff;
    nxt_kind    = kind_ff;
    nxt_cnt     = cnt_ff;
    nxt_sr      = sr_ff;
    nxt_hold    = hold_ff;
    nxt_rw      = rw_ff;
    nxt_ara     = ara_ff;
    nxt_ack_on  = ack_on_ff;
    nxt_first   = first_ff;
    nxt_mack    = mack_ff;
    nxt_sda_oe  = sda_oe_ff;
    nxt_ptr     = ptr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_stb  = 1'h0;
    alert_clr   = 1'h0;
    if (line.stop) begin
      // A stop frees the bus and drops any drive.
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'h0;
      nxt_ack_on = 1'h0;
    end else if (line.start) begin
      // Start or repeated start: an address byte follows.
      nxt_state  = ST_RX;
      nxt_kind   = KIND_ADDR;
      nxt_cnt    = 3'h0;
      nxt_sda_oe = 1'h0;
      nxt_ack_on = 1'h0;
    end else begin
      case (state_ff)
        ST_RX: begin
          // Shift one bit per rising edge, most significant first.
          if (line.scl_rise) begin
            nxt_sr  = rx_byte;
            nxt_cnt = cnt_ff + 3'h1;
            if (last_bit) begin
              nxt_state = ST_ACK;
              if (kind_ff == KIND_ADDR) begin
                // Unmatched address: stay silent until the next start.
                if (!addr_hit) begin
                  nxt_state = ST_IDLE;
                end
                nxt_rw   = rx_rw;
                nxt_ara  = ara_hit;
                alert_clr = own_hit;
                nxt_hold = ara_hit ? {own_addr, 1'h0} : reg_rd_data;
              end
            end
          end
        end
        ST_ACK: begin
          if (line.scl_fall && !ack_on_ff) begin
            // Pull low for the whole acknowledge pulse.
            nxt_ack_on = 1'h1;
            nxt_sda_oe = 1'h1;
          end else if (line.scl_fall) begin
            // Acknowledge pulse over: release and move on.
            nxt_ack_on = 1'h0;
            nxt_cnt    = 3'h0;
            nxt_sda_oe = 1'h0;
            nxt_state  = ST_RX;
            case (kind_ff)
              KIND_ADDR: begin
                if (rw_ff) begin
                  // Read: first bit goes out on this very fall.
                  nxt_state  = ST_TX;
                  nxt_sr     = hold_ff;
                  nxt_sda_oe = ~hold_ff[7];
                end else begin
                  nxt_kind = KIND_CMD;
                end
              end
              KIND_CMD: begin
                // Only the low three command bits pick a register.
                nxt_ptr   = sr_ff[2:0];
                nxt_kind  = KIND_DATA;
                nxt_first = 1'h1;
              end
              KIND_DATA: begin
                // First data byte is stored, later ones dropped.
                if (first_ff) begin
                  nxt_wr_data = sr_ff;
                  nxt_wr_stb  = 1'h1;
                end
                nxt_first = 1'h0;
              end
              default: nxt_state = ST_IDLE;
            endcase
          end
        end
        ST_TX: begin
          // Change the data bit on each falling edge.
          if (line.scl_fall) begin
            if (last_bit) begin
              // Eight bits out: free the line for the master's answer.
              nxt_sda_oe = 1'h0;
              nxt_state  = ST_MACK;
              nxt_mack   = 1'h0;
              alert_clr  = ara_ff;
            end else begin
              nxt_sr     = {sr_ff[6:0], 1'h0};
              nxt_sda_oe = ~sr_ff[6];
              nxt_cnt    = cnt_ff + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (line.scl_rise) begin
            nxt_mack = ~line.sda_lvl;
          end
          if (line.scl_fall) begin
            if (mack_ff) begin
              // Acknowledged: send the same byte again.
              nxt_state  = ST_TX;
              nxt_sr     = hold_ff;
              nxt_sda_oe = ~hold_ff[7];
              nxt_cnt    = 3'h0;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_IDLE: nxt_sda_oe = 1'h0;
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // Engine state and control bits.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff  <= ST_IDLE;
      kind_ff   <= KIND_ADDR;
      cnt_ff    <= 3'h0;
      rw_ff     <= 1'h0;
      ara_ff    <= 1'h0;
      ack_on_ff <= 1'h0;
      first_ff  <= 1'h0;
      mack_ff   <= 1'h0;
      sda_oe_ff <= 1'h0;
      wr_stb_ff <= 1'h0;
    end else begin
      state_ff  <= nxt_state;
      kind_ff   <= nxt_kind;
      cnt_ff    <= nxt_cnt;
      rw_ff     <= nxt_rw;
      ara_ff    <= nxt_ara;
      ack_on_ff <= nxt_ack_on;
      first_ff  <= nxt_first;
      mack_ff   <= nxt_mack;
      sda_oe_ff <= nxt_sda_oe;
      wr_stb_ff <= nxt_wr_stb;
    end
  end

  // Data path registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      sr_ff      <= SSRP_BYTE_RST;
      hold_ff    <= SSRP_BYTE_RST;
      ptr_ff     <= SSRP_PTR_RST;
      wr_data_ff <= SSRP_BYTE_RST;
    end else begin
      sr_ff      <= nxt_sr;
      hold_ff    <= nxt_hold;
      ptr_ff     <= nxt_ptr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // Alert flag: a new alert in the release cycle wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      alert_ff <= 1'h0;
    end else if (alert_set) begin
      alert_ff <= 1'h1;
    end else if (alert_clr) begin
      alert_ff <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Open-drain lines only ever pull low.
  assign sda_o       = 1'h0;
  assign sda_oe      = sda_oe_ff;
  assign alert_o     = 1'h0;
  assign alert_oe    = alert_ff;
  assign reg_ptr     = ptr_ff;
  assign reg_wr_data = wr_data_ff;
  assign reg_wr_stb  = wr_stb_ff;

endmodule

// ---- verilog/ssrp_pkg.sv ----
package ssrp_pkg;

  // ----------------------------------------------------------------------
  // Address constants
  // ----------------------------------------------------------------------

  // Upper two bits of the strapped slave address, fixed inside.
  localparam logic [1:0] SSRP_FIXED_MSBS      = 2'h2;
  // Common mass-write address, seven bits.
  localparam logic [6:0] SSRP_MASS_WRITE_ADDR = 7'h5F;
  // Alert response address, seven bits.
  localparam logic [6:0] SSRP_ALERT_RESP_ADDR = 7'h0C;
  // Base of the three spare strap codes (middle pin high, low pin low).
  localparam logic [4:0] SSRP_SPARE_BASE      = 5'h18;

  // ----------------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------------

  // Width of the internal register pointer.
  localparam int         SSRP_PTR_W     = 3;
  // Bit counter value of the last bit in a byte.
  localparam logic [2:0] SSRP_LAST_BIT  = 3'h7;
  // Pointer value after reset.
  localparam logic [2:0] SSRP_PTR_RST   = 3'h0;
  // Byte value after reset.
  localparam logic [7:0] SSRP_BYTE_RST  = 8'h00;
  // Number of strap pins.
  localparam int         SSRP_STRAP_N   = 3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------

  // Level seen on one tri-level strap pin.
  typedef enum logic [1:0] {
    SSRP_PIN_LOW,
    SSRP_PIN_OPEN,
    SSRP_PIN_HIGH
  } ssrp_pin_t;

  // Serial engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } ssrp_state_t;

  // Meaning of the byte now being received.
  typedef enum logic [1:0] {
    KIND_ADDR,
    KIND_CMD,
    KIND_DATA
  } ssrp_kind_t;

endpackage

// ---- verilog/ssrp_line_if.sv ----
`timescale 1ns/1ps

// Conditioned bus events passed from the line front end to the engine.
interface ssrp_line_if;
  logic       scl_rise;  // One-cycle pulse on a clock line rising edge.
  logic       scl_fall;  // One-cycle pulse on a clock line falling edge.
  logic       sda_lvl;   // Synchronised data line level.
  logic       start;     // One-cycle pulse on a start or repeated start.
  logic       stop;      // One-cycle pulse on a stop.
  logic [2:0] strap_hi;  // Synchronised strap comparator, pin high.
  logic [2:0] strap_lo;  // Synchronised strap comparator, pin low.

  modport fe (
    output scl_rise,
    output scl_fall,
    output sda_lvl,
    output start,
    output stop,
    output strap_hi,
    output strap_lo
  );

  modport core (
    input scl_rise,
    input scl_fall,
    input sda_lvl,
    input start,
    input stop,
    input strap_hi,
    input strap_lo
  );
endinterface

// ---- verilog/ssrp_line_front.sv ----
`timescale 1ns/1ps

// Synchronises the bus and strap pins and detects edges and conditions.
module ssrp_line_front (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Bus pins.
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // Strap comparators.
  input  wire logic [2:0] strap_hi_i,
  input  wire logic [2:0] strap_lo_i,
  // Conditioned events.
  ssrp_line_if.fe         line
);
  import ssrp_pkg::*;

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------

  logic       scl_meta_ff;  // First stage, read only by the second.
  logic       scl_sync_ff;  // Synchronised clock line.
  logic       scl_prev_ff;  // Clock line one cycle earlier.
  logic       sda_meta_ff;  // First stage, read only by the second.
  logic       sda_sync_ff;  // Synchronised data line.
  logic       sda_prev_ff;  // Data line one cycle earlier.
  logic [2:0] hi_meta_ff;   // Strap high, first stage.
  logic [2:0] hi_sync_ff;   // Strap high, synchronised.
  logic [2:0] lo_meta_ff;   // Strap low, first stage.
  logic [2:0] lo_sync_ff;   // Strap low, synchronised.

  // Idle bus lines rest high, so reset loads ones into the line stages.
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_meta_ff <= 1'h1;
      scl_sync_ff <= 1'h1;
      scl_prev_ff <= 1'h1;
      sda_meta_ff <= 1'h1;
      sda_sync_ff <= 1'h1;
      sda_prev_ff <= 1'h1;
    end else begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  // Strap pins pass two stages like any other pin.
  always_ff @(posedge clk) begin
    if (srst) begin
      hi_meta_ff <= 3'h0;
      hi_sync_ff <= 3'h0;
      lo_meta_ff <= 3'h0;
      lo_sync_ff <= 3'h0;
    end else begin
      hi_meta_ff <= strap_hi_i;
      hi_sync_ff <= hi_meta_ff;
      lo_meta_ff <= strap_lo_i;
      lo_sync_ff <= lo_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Edge and condition decode
  // ----------------------------------------------------------------------

  // Clock edges come from the two synchronised samples only.
  assign line.scl_rise = scl_sync_ff & ~scl_prev_ff;
  assign line.scl_fall = ~scl_sync_ff & scl_prev_ff;
  assign line.sda_lvl  = sda_sync_ff;
  // Data falling while the clock stays high marks a start.
  assign line.start    = scl_sync_ff & scl_prev_ff &
                         sda_prev_ff & ~sda_sync_ff;
  // Data rising while the clock stays high marks a stop.
  assign line.stop     = scl_sync_ff & scl_prev_ff &
                         ~sda_prev_ff & sda_sync_ff;
  assign line.strap_hi = hi_sync_ff;
  assign line.strap_lo = lo_sync_ff;

endmodule

// ---- dv/ssrp_port_props.sv ----
`timescale 1ns/1ps

// Checker on the serial port pins and the register strobe.
module ssrp_port_props (
  input wire logic                            clk,
  input wire logic                            srst,
  input wire logic                            scl_i,
  input wire logic                            sda_o,
  input wire logic                            sda_oe,
  input wire logic                            alert_o,
  input wire logic                            alert_oe,
  input wire logic                            alert_set,
  input wire logic [ssrp_pkg::SSRP_PTR_W-1:0] reg_ptr,
  input wire logic                            reg_wr_stb
);
  import ssrp_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_open_drain;
    sda_o == 1'b0 && alert_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_ack_hold;
    scl_i [*6] |-> $stable(sda_oe);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data drive moved while clock high");

  property p_oe_clk_low;
    $changed(sda_oe) |-> !scl_i;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low)
    else $error("data drive changed with clock high");

  property p_ptr_load;
    $changed(reg_ptr) |-> !scl_i && ($past(sda_oe) || $past(sda_oe, 2));
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer loaded outside acknowledge end");

  property p_stb_ack;
    reg_wr_stb |-> !scl_i && ($past(sda_oe) || $past(sda_oe, 2));
  endproperty
  a_stb_ack: assert property (p_stb_ack)
    else $error("store without acknowledge");

  property p_stb_gap;
    reg_wr_stb |=> !reg_wr_stb [*8];
  endproperty
  a_stb_gap: assert property (p_stb_gap)
    else $error("store strobes too close");

  property p_alert_on;
    alert_set |=> alert_oe;
  endproperty
  a_alert_on: assert property (p_alert_on)
    else $error("alert not raised");

  property p_alert_cause;
    $rose(alert_oe) |-> $past(alert_set);
  endproperty
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert raised without cause");
endmodule

bind ssrp_port ssrp_port_props u_props (
  .clk(clk), .srst(srst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .alert_o(alert_o), .alert_oe(alert_oe), .alert_set(alert_set),
  .reg_ptr(reg_ptr), .reg_wr_stb(reg_wr_stb)
);

// ---- dv/ssrp_master_model.sv ----
`timescale 1ns/1ps

// Bus master model; it drives the clock line and shares the data line.
module ssrp_master_model (
  // Clock.
  input  wire logic clk,
  // Slave drive of the data line.
  input  wire logic sda_o,
  input  wire logic sda_oe,
  // Resolved bus lines.
  output logic      scl,
  output wire logic sda
);
  logic sda_m;  // Master drive; one releases to the pull-up.

  // The pull-up wins unless a party pulls low.
  assign sda = sda_m & ~(sda_oe & ~sda_o);

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // Waits a number of falling edges of the system clock.
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_m = 1'b1;
    hold(6);
    scl = 1'b1;
    hold(12);
    sda_m = 1'b0;
    hold(12);
    scl = 1'b0;
    hold(6);
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_m = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(12);
    sda_m = 1'b1;
    hold(12);
  endtask

  // One clock pulse; drives b and samples the wire two cycles before the clock falls.
  task automatic pulse(input logic b, output logic r);
    sda_m = b;
    hold(6);
    scl = 1'b1;
    hold(10);
    r = sda;
    hold(2);
    scl = 1'b0;
    hold(6);
  endtask

  // Sends a byte MSB first; ack is high when the slave pulled low.
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(b[i], r);
    pulse(1'b1, r);
    ack = ~r;
  endtask

  // Receives a byte; mack low leaves the last byte unacknowledged.
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, r);
      d[i] = r;
    end
    pulse(~mack, r);
  endtask
endmodule

// ---- dv/ssrp_port_bench.sv ----
`timescale 1ns/1ps

module ssrp_port_bench;
  import ssrp_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic        clk, srst, alert_set, mwe, stb, sda_o, sda_oe;
  logic        alert_o, alert_oe;
  wire logic   scl, sda;
  logic [2:0]  s_hi, s_lo, ptr;
  logic [7:0]  wdat, rdat, d;
  logic [7:0]  regs [8];      // Register set behind the port.
  logic [10:0] exp_q [$];     // Expected stores as {pointer, data}.
  logic [10:0] e;
  logic [31:0] seed;
  logic [6:0]  own;           // Expected strapped address.
  logic        ak;
  int          n_fail, total_checks, cyc;
  int          amap [9] = '{4, 6, 7, 0, 2, 3, 8, 1, 5};

  assign rdat = regs[ptr];

  ssrp_port u_dut (
    .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe),
    .alert_set(alert_set), .address_strap_pins_hi(s_hi),
    .address_strap_pins_lo(s_lo), .mass_write_enable_bit(mwe),
    .reg_ptr(ptr), .reg_wr_data(wdat), .reg_wr_stb(stb),
    .reg_rd_data(rdat));

  ssrp_master_model u_mst (
    .clk(clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Counts one comparison and reports a difference at once.
  task automatic check(input string nm, input logic [10:0] ex, got);
    total_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Sets the pins to low (0), open (1) or high (2); works out the address.
  task automatic set_straps(input int c2, c1, c0);
    int m;
    m = amap[c1 * 3 + c0];
    @(negedge clk);
    s_hi = {c2 == 2, c1 == 2, c0 == 2};
    s_lo = {c2 != 1, c1 != 1, c0 != 1};
    own = (m == 8) ? {2'h2, SSRP_SPARE_BASE | 5'(c2)}
                   : {2'h2, 2'(c2), 3'(m)};
  endtask

  // Write of nb data bytes; ea says whether the address is answered.
  task automatic wr(input logic [6:0] a, input logic [7:0] c, dv,
                    input int nb, input logic ea);
    u_mst.start();
    u_mst.send({a, 1'b0}, ak);
    check("addr_ack", 11'(ea), 11'(ak));
    if (ak) begin
      exp_q.push_back({c[2:0], dv});
      for (int i = 0; i <= nb; i++) begin
        u_mst.send(i == 0 ? c : (i == 1 ? dv : ~dv), ak);
        check("byte_ack", 11'h001, 11'(ak));
      end
    end
    u_mst.stop();
  endtask

  // Read word: command, repeated start, two bytes, the last not acked.
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    u_mst.start();
    u_mst.send({a, 1'b0}, ak);
    u_mst.send(c, ak);
    u_mst.start();
    u_mst.send({a, 1'b1}, ak);
    check("rd_ack", 11'h001, 11'(ak));
    for (int i = 0; i < 2; i++) begin
      u_mst.recv(i == 0, d);
      check("rd_data", 11'(regs[c[2:0]]), 11'(d));
    end
    u_mst.stop();
  endtask

  // Pulses the alert request for one cycle.
  task automatic raise_alert();
    @(negedge clk);
    alert_set = 1'b1;
    @(negedge clk);
    alert_set = 1'b0;
    check("alert_on", 11'h001, 11'(alert_oe));
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard over the whole run.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      n_fail++;
      conclude();
    end
  end

  // Each store strobe takes the oldest expected store off the queue.
  always @(negedge clk) begin
    if (stb === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 11'bx;
      check("store", e, {ptr, wdat});
      regs[e[10:8]] = e[7:0];
    end
  end

  initial begin
    srst = 1'b1;
    alert_set = 1'b0;
    mwe = 1'b1;
    s_hi = 3'h0;
    s_lo = 3'h7;
    seed = 32'h0713;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      regs[i] = seed[7:0];
    end
    repeat (10) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    u_mst.hold(4);
    // Strap settings, byte and word writes, word reads.
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      set_straps(seed[3:0] % 3, seed[7:4] % 3, seed[11:8] % 3);
      wr(own, seed[23:16], seed[31:24], 1 + k % 2, 1'b1);
      rd(own, seed[15:8]);
    end
    wr(own ^ 7'h40, 8'h01, 8'hA5, 1, 1'b0);
    wr(SSRP_MASS_WRITE_ADDR, 8'hF3, seed[7:0], 1, 1'b1);
    mwe = 1'b0;
    wr(SSRP_MASS_WRITE_ADDR, 8'h02, 8'h5A, 1, 1'b0);
    mwe = 1'b1;
    // Alert response: acked, own address sent, alert released.
    raise_alert();
    u_mst.start();
    u_mst.send({SSRP_ALERT_RESP_ADDR, 1'b1}, ak);
    check("ara_ack", 11'h001, 11'(ak));
    u_mst.recv(1'b0, d);
    check("ara_addr", 11'({own, 1'b0}), 11'(d));
    u_mst.stop();
    check("alert_off", 11'h000, 11'(alert_oe));
    u_mst.start();
    u_mst.send({SSRP_ALERT_RESP_ADDR, 1'b1}, ak);
    check("ara_idle", 11'h000, 11'(ak));
    u_mst.stop();
    raise_alert();
    wr(own, 8'h04, 8'h3C, 1, 1'b1);
    check("alert_own", 11'h000, 11'(alert_oe));
    check("pending", 11'h000, 11'(exp_q.size()));
    conclude();
  end
endmodule
